/* File: logic/cbt_ctrl.sv */
// can bit timing logic and general-purpose control registers
// assumes an 8-bit cpu register port on clk_sys_i and a core reporting events
// overview of the bus: rx line is asynchronous and passes a 3-stage filter
// Overview of operation
// - edge segment fixed at one quantum
// - first segment 1..16 quanta, lengthened on drift
// - second segment 1..8 quanta, shortened on drift
// - lengthening limited by jump width field+1; early edge always restarts bit
// - timing registers writable only in standby
// - quantum is cpu clocks times divider+1
// - segment fields bits 6:4 and 3:0, reset 23h
// - three-bit page code selects register window
// - receive flags set per buffer, cleared
// - sent flag on completion or arbitration win
// - status flag on wake, passive, bus-off, errors
// - overrun and send error flags set on events
// - error pending follows the three error flags
// - flags cleared where zero written, receive flags also on ready clear
// - interrupts gated by enable bits five..one
// - early mode moves sent event to arbitration
// - bus-off and error-passive read-only status bits
// - self reception selectable
// - no-retry bit disables retransmission
// - wake pulse then 11 or 128x11 recessive
// - run reads one until transfer completes
module cbt_ctrl
   import cbt_pkg::*;
(
   input  wire logic        clk_sys_i,   // cpu clock, 100 mhz
   input  wire logic        rst_b_i,     // async reset, active low
   input  wire logic [7:0]  addr_i,      // register address
   input  wire logic        wr_i,        // write strobe
   input  wire logic [7:0]  wdata_i,     // write data
   output logic      [7:0]  rdata_o,     // read data, registered
   input  wire logic        can_rx_i,    // bus line, 0 = dominant
   input  wire cbt_core_s   core_i,      // protocol core events
   output cbt_timing_s      timing_o,    // timing strobes and controls
   output logic             irq_o        // interrupt request
);
   typedef struct packed
   {
      logic [7:0] flags;
      logic [7:0] enables;
      logic [4:0] ctl;        // self, noretry, fast, wake, run bits
      logic [7:0] prescaler;
      logic [6:0] segments;
      logic [2:0] page;
      logic [7:0] rdata;
      cbt_mode_e  mode;
      cbt_seg_e   seg;
      logic [5:0] qcnt;
      logic       tq;
      logic [4:0] scnt;
      logic [4:0] seg1_len;
      logic [3:0] seg2_len;
      logic [2:0] rx_sync;
      logic       rx_stable;
      logic       rx_bit;
      logic [3:0] rec_cnt;
      logic [6:0] seq_cnt;
      logic       passive_q;
      logic       bus_off_state_q;
      logic       sample;
      logic       tx_point;
   } cbt_state_s;

   cbt_state_s r;
   cbt_state_s next_r;

   // clamp an adjustment to the jump width
   function automatic logic [4:0] clamp_jump(input logic [4:0] amt,
                                             input logic [1:0] width);
      logic [4:0] lim;
      lim = {3'h0, width} + 5'h01;
      clamp_jump = (amt > lim) ? lim : amt;
   endfunction : clamp_jump

   logic       standby;
   logic       edge_seen;
   logic       bus_off_state;
   logic       passive;
   logic [7:0] clr_mask;
   logic       sent_ev;
   logic       sc_ev;

   always_comb
   begin
      next_r    = r;
      standby   = (r.mode == ST_STANDBY);
      bus_off_state      = core_i.tx_err_cnt > 9'h0ff;
      passive   = !bus_off_state && (core_i.tx_err_cnt > 9'h07f ||
                            core_i.rx_err_cnt > 8'h7f);
      edge_seen = r.rx_stable && !r.rx_bit;  // stable and now dominant
      clr_mask  = 8'hff;
      sent_ev   = r.enables[EN_EARLY] ? core_i.arb_won : core_i.tx_ok;

      // three-stage line filter: change accepted when stages 2 and 3 agree
      next_r.rx_sync   = {r.rx_sync[1:0], can_rx_i};
      next_r.rx_stable = 1'b0;
      if (r.rx_sync[2] == r.rx_sync[1] && r.rx_sync[2] != r.rx_bit)
      begin
         next_r.rx_bit    = r.rx_sync[2];
         next_r.rx_stable = 1'b1;
      end

      // register writes
      if (wr_i)
      begin
         unique case (addr_i)
            OFS_FLAGS:   clr_mask = wdata_i;
            OFS_ENABLES: next_r.enables = {1'b0, wdata_i[6:0]};
            OFS_CONTROL: next_r.ctl = wdata_i[4:0];
            OFS_PRESCALER:
               if (standby) next_r.prescaler = wdata_i;
            OFS_SEGMENTS:
               if (standby) next_r.segments = wdata_i[6:0];
            OFS_PAGE:    next_r.page = wdata_i[2:0];
            default: ;
         endcase
      end

      // flags: clear by zero, then events set, so a set wins
      sc_ev = (standby && edge_seen) ||
              (!standby && ((passive && !r.passive_q) ||
                            (bus_off_state && !r.bus_off_state_q))) ||
              (r.enables[EN_EXTENDED_STATUS_REPORTING] && core_i.rx_err);
      next_r.flags[7:1] = r.flags[7:1] & clr_mask[7:1];
      next_r.flags[7:5] = next_r.flags[7:5] & ~{core_i.rdy_clear[2],
                            core_i.rdy_clear[1], core_i.rdy_clear[0]};
      next_r.flags[7:5] = next_r.flags[7:5] | {core_i.rx_done[2],
                            core_i.rx_done[1], core_i.rx_done[0]};
      if (sent_ev)        next_r.flags[FL_SENT] = 1'b1;
      if (sc_ev)          next_r.flags[FL_SC]   = 1'b1;
      if (core_i.overrun) next_r.flags[FL_OVR]  = 1'b1;
      if (core_i.tx_err)  next_r.flags[FL_TERR] = 1'b1;
      next_r.flags[FL_PEND] = |next_r.flags[FL_SC:FL_TERR];
      next_r.passive_q = passive;
      next_r.bus_off_state_q    = bus_off_state;

      // node mode sequencing
      next_r.sample   = 1'b0;
      next_r.tx_point = 1'b0;
      unique case (r.mode)
         ST_STANDBY:
            if (r.ctl[CTL_RUN])
               next_r.mode = r.ctl[CTL_WAKE] ? ST_WAKEUP : ST_RESYNC;
         ST_WAKEUP:
            if (r.tx_point) next_r.mode = ST_RESYNC;  // one bit dominant
         ST_RESYNC:
         begin
            if (!r.ctl[CTL_RUN]) next_r.mode = ST_STANDBY;
            else if (r.sample)
            begin
               if (!r.rx_bit) begin next_r.rec_cnt = 4'h0;
                  next_r.seq_cnt = 7'h00; end
               else if (r.rec_cnt != RECESSIVE_RUN)
                  next_r.rec_cnt = r.rec_cnt + 4'h1;
               else if (r.ctl[CTL_FAST] && !bus_off_state ||
                        r.seq_cnt == RUN_SEQUENCES)
                  next_r.mode = ST_RUN;
               else
               begin
                  next_r.rec_cnt = 4'h0;
                  next_r.seq_cnt = r.seq_cnt + 7'h01;
               end
            end
         end
         ST_RUN:
            if (!r.ctl[CTL_RUN]) next_r.mode = ST_DRAIN;
         ST_DRAIN:
            if (r.ctl[CTL_RUN]) next_r.mode = ST_RUN;
            else if (!core_i.busy) next_r.mode = ST_STANDBY;
         default: next_r.mode = ST_STANDBY;
      endcase
      if (next_r.mode != ST_RESYNC)
      begin
         next_r.rec_cnt = 4'h0;
         next_r.seq_cnt = 7'h00;
      end

      // quantum generation; prescaler stopped in standby
      next_r.tq = 1'b0;
      if (standby) next_r.qcnt = 6'h00;
      else if (r.qcnt == r.prescaler[5:0])
      begin
         next_r.qcnt = 6'h00;
         next_r.tq   = 1'b1;
      end
      else next_r.qcnt = r.qcnt + 6'h01;

      // bit segments
      if (standby)
      begin
         next_r.seg  = SEG_EDGE;
         next_r.scnt = 5'h00;
      end
      else if (edge_seen && r.seg == SEG_FIRST)
         // late edge: lengthen first segment
         next_r.seg1_len = r.seg1_len + clamp_jump(r.scnt + 5'h01,
                                     r.prescaler[7:6]);
      else if (edge_seen && r.seg == SEG_SECOND)
      begin
         // early edge: cut second segment, restart bit
         next_r.seg  = SEG_EDGE;
         next_r.scnt = 5'h00;
         next_r.tx_point = (5'({1'b0, r.seg2_len}) - r.scnt) <=
                           clamp_jump(5'({1'b0, r.seg2_len}) - r.scnt,
                                      r.prescaler[7:6]);
      end
      if (r.tq && !standby)
      begin
         unique case (r.seg)
            SEG_EDGE:
            begin
               next_r.seg      = SEG_FIRST;
               next_r.scnt     = 5'h00;
               next_r.seg1_len = {1'b0, r.segments[3:0]} + 5'h01;
               next_r.seg2_len = {1'b0, r.segments[6:4]} + 4'h1;
            end
            SEG_FIRST:
               if (r.scnt + 5'h01 >= r.seg1_len)
               begin
                  next_r.seg    = SEG_SECOND;
                  next_r.scnt   = 5'h00;
                  next_r.sample = 1'b1;
               end
               else next_r.scnt = r.scnt + 5'h01;
            SEG_SECOND:
               if (r.scnt + 5'h01 >= {1'b0, r.seg2_len})
               begin
                  next_r.seg      = SEG_EDGE;
                  next_r.scnt     = 5'h00;
                  next_r.tx_point = 1'b1;
               end
               else next_r.scnt = r.scnt + 5'h01;
            default: next_r.seg = SEG_EDGE;
         endcase
      end

      // read data
      unique case (addr_i)
         OFS_FLAGS:     next_r.rdata = r.flags;
         OFS_ENABLES:   next_r.rdata = r.enables;
         OFS_CONTROL:   next_r.rdata = {1'b0, bus_off_state, passive, r.ctl[4:1],
                                        r.ctl[0] || r.mode == ST_DRAIN};
         OFS_PRESCALER: next_r.rdata = r.prescaler;
         OFS_SEGMENTS:  next_r.rdata = {1'b0, r.segments};
         OFS_PAGE:      next_r.rdata = {5'h00, r.page};
         default:       next_r.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         r           <= '0;
         r.flags     <= RST_FLAGS;
         r.enables   <= RST_ENABLES;
         r.ctl       <= RST_CONTROL[4:0];
         r.prescaler <= RST_PRESCALER;
         r.segments  <= RST_SEGMENTS[6:0];
         r.page      <= RST_PAGE;
         r.mode      <= ST_STANDBY;
         r.seg       <= SEG_EDGE;
         r.rx_sync   <= 3'h7;
         r.rx_bit    <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign rdata_o             = r.rdata;
   assign timing_o.sample     = r.sample;
   assign timing_o.tx_point   = r.tx_point;
   assign timing_o.synced     = (r.mode == ST_RUN) || (r.mode == ST_DRAIN);
   assign timing_o.wake_drive = (r.mode == ST_WAKEUP);
   assign timing_o.self_rx    = r.ctl[CTL_SELF];
   assign timing_o.no_retry   = r.ctl[CTL_NORT];
   assign timing_o.page       = r.page;
   assign timing_o.page_valid = (r.page <= PG_FILT);
   // interrupt: receive flags share one enable
   assign irq_o = (|r.flags[7:5] && r.enables[5]) ||
                  (r.flags[FL_SENT] && r.enables[4]) ||
                  (r.flags[FL_SC]   && r.enables[3]) ||
                  (r.flags[FL_OVR]  && r.enables[2]) ||
                  (r.flags[FL_TERR] && r.enables[1]);
endmodule : cbt_ctrl

/* File: logic/cbt_pkg.sv */
// package for the can bit timing and control block: offsets, fields, types
// assumes an 8-bit cpu register port on the cpu clock
package cbt_pkg;
   localparam logic [7:0] OFS_FLAGS     = 8'h5a;
   localparam logic [7:0] OFS_ENABLES   = 8'h5b;
   localparam logic [7:0] OFS_CONTROL   = 8'h5c;
   localparam logic [7:0] OFS_PRESCALER = 8'h5d;
   localparam logic [7:0] OFS_SEGMENTS  = 8'h5e;
   localparam logic [7:0] OFS_PAGE      = 8'h5f;
   localparam logic [7:0] RST_FLAGS     = 8'h00;
   localparam logic [7:0] RST_ENABLES   = 8'h00;
   localparam logic [7:0] RST_CONTROL   = 8'h00;
   localparam logic [7:0] RST_PRESCALER = 8'h00;
   localparam logic [7:0] RST_SEGMENTS  = 8'h23;
   localparam logic [2:0] RST_PAGE      = 3'h0;
   // control register bit positions
   localparam int CTL_RUN  = 0;
   localparam int CTL_WAKE = 1;
   localparam int CTL_FAST = 2;
   localparam int CTL_NORT = 3;
   localparam int CTL_SELF = 4;
   localparam int CTL_ERROR_PASSIVE_STATE = 5;
   localparam int CTL_BUS_OFF_STATE = 6;
   // enables register bit positions
   localparam int EN_EARLY = 0;
   localparam int EN_EXTENDED_STATUS_REPORTING  = 6;
   // flag register bit positions
   localparam int FL_PEND = 0;
   localparam int FL_TERR = 1;
   localparam int FL_OVR  = 2;
   localparam int FL_SC   = 3;
   localparam int FL_SENT = 4;
   localparam int FL_RX1  = 5;
   // resync counts
   localparam logic [3:0] RECESSIVE_RUN = 4'ha;  // 11 bits, counted 0..10
   localparam logic [6:0] RUN_SEQUENCES = 7'h7f; // 128 runs, counted 0..127
   // page codes
   localparam logic [2:0] PG_DIAG = 3'h0;
   localparam logic [2:0] PG_BUF1 = 3'h1;
   localparam logic [2:0] PG_BUF2 = 3'h2;
   localparam logic [2:0] PG_BUF3 = 3'h3;
   localparam logic [2:0] PG_FILT = 3'h4;

   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b000,
      ST_WAKEUP  = 3'b001,
      ST_RESYNC  = 3'b010,
      ST_RUN     = 3'b011,
      ST_DRAIN   = 3'b100
   } cbt_mode_e;

   typedef enum logic [1:0]
   {
      SEG_EDGE   = 2'b00,
      SEG_FIRST  = 2'b01,
      SEG_SECOND = 2'b10
   } cbt_seg_e;

   // events reported by the protocol core as one-cycle pulses, plus the busy level and error counts
   typedef struct packed
   {
      logic [2:0] rx_done;     // error-free message stored, per buffer
      logic [2:0] rdy_clear;   // software cleared message-ready, per buffer
      logic       arb_won;
      logic       tx_ok;
      logic       tx_err;
      logic       rx_err;
      logic       overrun;
      logic       busy;        // transfer in progress
      logic [8:0] tx_err_cnt;
      logic [7:0] rx_err_cnt;
   } cbt_core_s;

   // bit timing strobes toward the protocol core
   typedef struct packed
   {
      logic       sample;      // sample point
      logic       tx_point;    // transmit point
      logic       synced;      // node running and synchronised
      logic       wake_drive;  // forcing the line dominant
      logic       self_rx;
      logic       no_retry;
      logic [2:0] page;
      logic       page_valid;
   } cbt_timing_s;
endpackage : cbt_pkg

/* File: verification/cbt_bus_node.sv */
// other nodes of the shared bus, reduced to a dominant driver
// assumes recessive 1 and a line pulled recessive when nobody drives
module cbt_bus_node
(
   input  wire logic dom_req_i,  // other node sends dominant
   input  wire logic wake_dom_i, // device wake-up drive
   output logic      line_o      // resolved bus level
);
   timeunit 1ns;
   timeprecision 1ps;
   // wired-and: any dominant wins, a released line is recessive
   assign line_o = !(dom_req_i || wake_dom_i);
endmodule : cbt_bus_node

/* File: verification/cbt_ctrl_checker.sv */
// port checker for the bit timing and control block
// assumes binding to cbt_ctrl, package compiled first
module cbt_ctrl_checker
   import cbt_pkg::*;
(
   input wire logic        clk_sys_i, // cpu clock
   input wire logic        rst_b_i,   // async reset
   input wire logic [7:0]  addr_i,    // address
   input wire logic        wr_i,      // write strobe
   input wire logic [7:0]  wdata_i,   // write data
   input wire logic [7:0]  rdata_o,   // read data
   input wire cbt_core_s   core_i,    // core events
   input wire cbt_timing_s timing_o,  // strobes
   input wire logic        irq_o      // request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] en_q;
   logic       en_wr;
   assign en_wr = wr_i && addr_i == OFS_ENABLES;
   // shadow of the enables, which no hardware event alters
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
      if (!rst_b_i)
         en_q <= RST_ENABLES;
      else if (en_wr)
         en_q <= wdata_i;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   a_en_readback: assert property (
      en_wr ##1 (addr_i == OFS_ENABLES && !wr_i)
      |=> rdata_o == ($past(wdata_i, 2) & 8'h7f)) else $error("enables");
   a_page_follows: assert property (
      wr_i && addr_i == OFS_PAGE |=> timing_o.page == $past(wdata_i[2:0]))
      else $error("page code");
   a_page_valid: assert property (
      timing_o.page_valid == (timing_o.page <= PG_FILT)) else $error("valid");
   a_ctl_bits: assert property (
      wr_i && addr_i == OFS_CONTROL |=> timing_o.self_rx ==
      $past(wdata_i[CTL_SELF]) && timing_o.no_retry == $past(wdata_i[CTL_NORT]))
      else $error("control bits");
   a_irq_gated: assert property (
      en_q[5:1] == 5'h00 |-> !irq_o) else $error("ungated irq");
   a_sent_irq: assert property (
      en_q[4] && !en_wr && (en_q[EN_EARLY] ? core_i.arb_won : core_i.tx_ok)
      |=> irq_o) else $error("sent irq");
   a_err_irq: assert property (
      !en_wr && (en_q[1] && core_i.tx_err || en_q[2] && core_i.overrun)
      |=> irq_o) else $error("error irq");
   a_rx_irq: assert property (
      en_q[5] && !en_wr && |core_i.rx_done |=> irq_o) else $error("rx irq");
   a_pending_read: assert property (
      $past(addr_i) == OFS_FLAGS |-> rdata_o[FL_PEND] == |rdata_o[3:1])
      else $error("pending bit");
   c_synced: cover property (timing_o.synced);
   c_irq: cover property (irq_o);
   c_bad_page: cover property (!timing_o.page_valid);
endmodule : cbt_ctrl_checker

/* File: verification/tb_top.sv */
// self-checking bench for the bit timing and control block
// assumes package, design, checker and bus node compiled before
module tb_top
   import cbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        wr_i = 1'b0;
   logic        dom_req = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic [7:0]  rdata_o;
   logic [7:0]  d;
   logic [7:0]  fl;
   cbt_core_s   core_i = '0;
   cbt_timing_s timing_o;
   logic        irq_o;
   logic        can_line;
   int          bad_count = 0;
   int          checked = 0;
   int          cyc = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   cbt_bus_node node (.dom_req_i(dom_req), .wake_dom_i(timing_o.wake_drive),
      .line_o(can_line));
   cbt_ctrl dut (.clk_sys_i, .rst_b_i, .addr_i, .wr_i, .wdata_i, .rdata_o,
      .can_rx_i(can_line), .core_i, .timing_o, .irq_o);
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp,
      input string what);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      addr_i <= a;
      @(posedge clk_sys_i);
      #1 d = rdata_o;
   endtask : rd
   // p: rx_done, rdy_clear, arb_won, tx_ok, tx_err, rx_err, overrun
   task automatic ev(input logic [10:0] p);
      @(posedge clk_sys_i);
      core_i[28:18] <= p;
      @(posedge clk_sys_i);
      core_i[28:18] <= 11'h000;
   endtask : ev
   task automatic next_sample(output int n);
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1 n++;
      end while (timing_o.sample !== 1'b1 && n < 500);
   endtask : next_sample
   function automatic logic [7:0] flags_of(logic [10:0] p, logic [7:0] en,
      logic [7:0] f);
      logic [7:0] n;
      n = f | {p[10:8], en[0] ? p[4] : p[3], p[1] & en[6], p[0], p[2], 1'b0};
      n[0] = |n[3:1];
      return n;
   endfunction : flags_of
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      logic [10:0] p;
      logic [7:0]  en;
      logic [7:0]  w;
      logic [7:0]  psc;
      int          n;
      int          per;
      logic        wk;
      logic [7:0]  tab [6];
      tab = '{RST_FLAGS, RST_ENABLES, RST_CONTROL, RST_PRESCALER,
         RST_SEGMENTS, {5'h00, RST_PAGE}};
      p = 11'($urandom(42363));
      repeat (10) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd(OFS_FLAGS + 8'(i));
         chk(d, tab[i], "reset value");
      end
      rd(8'h40);
      chk(d, 8'h00, "unmapped");
      w = 8'($urandom) & 8'hc3;
      wr(OFS_PRESCALER, w);
      wr(OFS_SEGMENTS, 8'h12);
      rd(OFS_PRESCALER);
      chk(d, w, "prescaler");
      // keep the divider apart, w is reused for random clear masks
      psc = w;
      rd(OFS_SEGMENTS);
      chk(d, 8'h12, "segments");
      for (int i = 0; i < 8; i++)
      begin
         wr(OFS_PAGE, 8'(i));
         #1 chk(timing_o.page, 9'(i), "page");
         chk(timing_o.page_valid, i < 5, "page valid");
      end
      $display("test registers done");
      @(posedge clk_sys_i);
      dom_req <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      dom_req <= 1'b0;
      rd(OFS_FLAGS);
      chk(d, 8'h09, "wake status");
      wr(OFS_FLAGS, 8'h00);
      ev(11'h600);
      ev(11'h040);
      rd(OFS_FLAGS);
      chk(d, 8'h80, "ready clear");
      wr(OFS_FLAGS, 8'h00);
      fl = 8'h00;
      for (int k = 0; k < 16; k++)
      begin
         en = 8'($urandom);
         p = 11'($urandom) & 11'h71f;
         wr(OFS_ENABLES, en);
         ev(p);
         fl = flags_of(p, en, fl);
         rd(OFS_FLAGS);
         chk(d, fl, "flags");
         chk(irq_o, |(fl[7:1] & {en[5], en[5], en[5:1]}), "irq");
         w = 8'($urandom);
         wr(OFS_FLAGS, w);
         fl = fl & {w[7:1], 1'b1};
         fl[0] = |fl[3:1];
         rd(OFS_FLAGS);
         chk(d, fl, "cleared flags");
      end
      $display("test flags done");
      @(posedge clk_sys_i);
      core_i.tx_err_cnt <= 9'd200;
      rd(OFS_CONTROL);
      chk(d[6:5], 2'b01, "passive");
      core_i.tx_err_cnt <= 9'd300;
      rd(OFS_CONTROL);
      chk(d[6:5], 2'b10, "bus off");
      core_i.tx_err_cnt <= 9'd0;
      wr(OFS_CONTROL, 8'h17);
      wk = 1'b0;
      for (n = 0; n < 3000 && timing_o.synced !== 1'b1; n++)
      begin
         @(posedge clk_sys_i);
         #1 wk |= timing_o.wake_drive;
      end
      chk(timing_o.synced, 1'b1, "synced");
      chk(wk, 1'b1, "wake pulse");
      per = (psc[5:0] + 1) * 6;
      chk(n >= 11 * per, 1'b1, "resync length");
      next_sample(n);
      next_sample(n);
      chk(9'(n), 9'(per), "bit period");
      wr(OFS_PRESCALER, ~psc);
      wr(OFS_SEGMENTS, 8'h7f);
      rd(OFS_PRESCALER);
      chk(d, psc, "locked prescaler");
      rd(OFS_SEGMENTS);
      chk(d, 8'h12, "locked segments");
      @(posedge clk_sys_i);
      core_i.busy <= 1'b1;
      wr(OFS_CONTROL, 8'h16);
      repeat (20) @(posedge clk_sys_i);
      rd(OFS_CONTROL);
      chk(d[0], 1'b1, "run held");
      @(posedge clk_sys_i);
      core_i.busy <= 1'b0;
      for (n = 0; n < 100 && d[0] !== 1'b0; n++)
         rd(OFS_CONTROL);
      chk(d[0], 1'b0, "standby");
      $display("test run done");
      conclude();
   end
endmodule : tb_top
bind cbt_ctrl cbt_ctrl_checker chk_u (.clk_sys_i, .rst_b_i, .addr_i, .wr_i,
   .wdata_i, .rdata_o, .core_i, .timing_o, .irq_o);
